// *** hdl/ssp_pkg.sv ***
package ssp_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_REL = 8'h04;
  localparam logic [7:0] OFF_DIR_A = 8'h08;
  localparam logic [7:0] OFF_DIR_B = 8'h0C;
  localparam logic [7:0] OFF_OUT_A = 8'h10;
  localparam logic [7:0] OFF_OUT_B = 8'h14;
  localparam logic [7:0] OFF_PIN_A = 8'h18;
  localparam logic [7:0] OFF_PIN_B = 8'h1C;
  localparam logic [7:0] OFF_TSEL = 8'h20;
  // control field positions
  localparam int C_NAND = 0;
  localparam int C_CARD = 1;
  localparam int C_DISK = 2;
  localparam int C_SER = 3;
  localparam int C_TIM = 4;
  localparam int C_ALTQ = 5;
  localparam int C_IRQM = 6;
  // register widths: group a is {r,q}, group b is {u,t,s}
  localparam int CTRL_W = 7;
  localparam int A_W = 16;
  localparam int B_W = 18;
  // reset values
  localparam logic [6:0] CTRL_RESET = 7'h00;
  localparam logic [7:0] REL_RESET = 8'h00;
  localparam logic [7:0] TSEL_RESET = 8'h00;
  localparam logic [15:0] GP_A_RESET = 16'h0000;
  localparam logic [17:0] GP_B_RESET = 18'h00000;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // eight-pin drive group
  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe;
  } ssp_bus8_type;
  // flash-card host outputs toward the pads
  typedef struct packed {
    logic [10:0] addr;
    logic write_strobe, io_write, io_read;
    logic enable_hi, enable_lo, output_enable;
    logic register_select;
    logic [7:0] dout;
    logic doe;
  } ssp_card_out_type;
  // flash-card host inputs from the pads
  typedef struct packed {
    logic ready, irq, wide_io_select;
    logic input_ack, wait_in;
    logic [7:0] din;
  } ssp_card_in_type;
  // disk host outputs toward the pads
  typedef struct packed {
    logic [2:0] addr;
    logic io_write, io_read, select_hi, select_lo, dma_ack;
    logic [7:0] dout;
    logic doe;
  } ssp_disk_out_type;
  // disk host inputs from the pads
  typedef struct packed {
    logic irq, dma_request, io_ready;
    logic [7:0] din;
  } ssp_disk_in_type;
endpackage

// *** hdl/ssp_pin_mux.sv ***
`timescale 1ns/1ns
// Behaviour
// (RULE_01) nand host enabled owns all q pins
// (RULE_02) otherwise q may carry card/disk data
// (RULE_03) r1..r0 card address 4..3, each releasable
// (RULE_04) r2 card address 5, else serial receive
// (RULE_05) r3 card address 6, else serial transmit
// (RULE_06) r7..r4 card address 10..7, else timer
// (RULE_07) s7 card ready/irq, else disk irq
// (RULE_08) s6 card write strobe, else disk dma request
// (RULE_09) s5..s4 card/disk io write and read
// (RULE_10) s3,s0 card enables, else disk selects
// (RULE_11) s2 card wide io select, else gpio
// (RULE_12) s1 card output enable, else gpio
// (RULE_13) t3..t0 timer channels when timer enabled
// (RULE_14) u5..u3 card address 2..0, else disk address
// (RULE_15) u2 card register select, else gpio
// (RULE_16) u1 card input ack, else disk dma ack
// (RULE_17) u0 card wait, else disk io ready
// (RULE_18) reset leaves every pin an input
// (RULE_19) unclaimed pins follow general purpose registers
module ssp_pin_mux
  import ssp_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pads
  input wire logic [7:0] q_in,
  output logic [7:0] q_out,
  output logic [7:0] q_oe,
  input wire logic [7:0] r_in,
  output logic [7:0] r_out,
  output logic [7:0] r_oe,
  input wire logic [7:0] s_in,
  output logic [7:0] s_out,
  output logic [7:0] s_oe,
  input wire logic [3:0] t_in,
  output logic [3:0] t_out,
  output logic [3:0] t_oe,
  input wire logic [5:0] u_in,
  output logic [5:0] u_out,
  output logic [5:0] u_oe,
  // peripheral side
  input wire ssp_bus8_type nand_drv,
  output logic [7:0] nand_din,
  input wire ssp_card_out_type card_drv,
  output ssp_card_in_type card_rcv,
  input wire ssp_disk_out_type disk_drv,
  output ssp_disk_in_type disk_rcv,
  input wire logic serial_tx,
  output logic serial_rx,
  input wire ssp_bus8_type tim_drv,
  output logic [7:0] tim_din
);

  // software registers
  logic [CTRL_W-1:0] ctrl; // module enables and options
  logic [7:0] rel; // card release of r pins
  logic [7:0] tsel; // timer channel pin select
  logic [A_W-1:0] gp_dir_a; // gpio direction {r,q}
  logic [A_W-1:0] gp_out_a; // gpio value {r,q}
  logic [B_W-1:0] gp_dir_b; // gpio direction {u,t,s}
  logic [B_W-1:0] gp_out_b; // gpio value {u,t,s}
  logic [A_W-1:0] pin_a; // sampled pins {r,q}
  logic [B_W-1:0] pin_b; // sampled pins {u,t,s}
  // write channel state
  logic aw_got, w_got;
  logic [7:0] aw_q;
  logic [31:0] wd_q;
  logic [3:0] ws_q;
  logic do_write, next_aw_got, next_w_got;
  logic [32:0] wr_cur; // {hit, current word} at write address
  logic [31:0] wr_val; // merged write word
  logic [32:0] rd_cur; // {hit, word} at read address
  logic next_rvalid;
  // pin routing results
  logic [7:0] card_own; // r pins the card host holds
  logic [7:0] next_q_out, next_q_oe, next_r_out, next_r_oe;
  logic [7:0] next_s_out, next_s_oe;
  logic [3:0] next_t_out, next_t_oe;
  logic [5:0] next_u_out, next_u_oe;
  logic [7:0] next_nand_din, next_tim_din;
  ssp_card_in_type next_card_rcv;
  ssp_disk_in_type next_disk_rcv;
  logic next_serial_rx;

  // register read decode: bit 32 flags a mapped address
  function automatic logic [32:0] rd_word(input logic [7:0] a);
    logic [32:0] w;
    w = 33'h1_0000_0000;
    case (a)
      OFF_CTRL: w[CTRL_W-1:0] = ctrl;
      OFF_REL: w[7:0] = rel;
      OFF_TSEL: w[7:0] = tsel;
      OFF_DIR_A: w[A_W-1:0] = gp_dir_a;
      OFF_DIR_B: w[B_W-1:0] = gp_dir_b;
      OFF_OUT_A: w[A_W-1:0] = gp_out_a;
      OFF_OUT_B: w[B_W-1:0] = gp_out_b;
      OFF_PIN_A: w[A_W-1:0] = pin_a;
      OFF_PIN_B: w[B_W-1:0] = pin_b;
      default: w = 33'h0_0000_0000;
    endcase
    return w;
  endfunction

  // byte-lane merge of a write into the current word
  function automatic logic [31:0] merge(
    input logic [31:0] cur,
    input logic [31:0] val,
    input logic [3:0] strb
  );
    logic [31:0] m;
    m = cur;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        m[b*8 +: 8] = val[b*8 +: 8];
      end
    end
    return m;
  endfunction

  // write handshake bookkeeping, address and data in either order
  always_comb begin
    do_write = aw_got && w_got && !s_axi_bvalid;
    next_aw_got = (aw_got || (s_axi_awvalid && s_axi_awready)) && !do_write;
    next_w_got = (w_got || (s_axi_wvalid && s_axi_wready)) && !do_write;
    wr_cur = rd_word(aw_q);
    wr_val = merge(wr_cur[31:0], wd_q, ws_q);
    rd_cur = rd_word(s_axi_araddr);
    next_rvalid = (s_axi_arvalid && s_axi_arready) || (s_axi_rvalid && !s_axi_rready);
  end

  // write address, data and response channels
  always_ff @(posedge mclk) begin
    if (rst) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_q <= 8'h00;
      wd_q <= 32'h0000_0000;
      ws_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      s_axi_awready <= !next_aw_got;
      s_axi_wready <= !next_w_got;
      // capture each channel when it is taken
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      // response once both halves are in
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_cur[32] ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read channel, one read in flight
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !next_rvalid;
      s_axi_rvalid <= next_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rdata <= rd_cur[31:0];
        s_axi_rresp <= rd_cur[32] ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // software register writes; pin status is read only
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl <= CTRL_RESET;
      rel <= REL_RESET;
      tsel <= TSEL_RESET;
      gp_dir_a <= GP_A_RESET;
      gp_out_a <= GP_A_RESET;
      gp_dir_b <= GP_B_RESET;
      gp_out_b <= GP_B_RESET;
    end else if (do_write) begin
      case (aw_q)
        OFF_CTRL: ctrl <= wr_val[CTRL_W-1:0];
        OFF_REL: rel <= wr_val[7:0];
        OFF_TSEL: tsel <= wr_val[7:0];
        OFF_DIR_A: gp_dir_a <= wr_val[A_W-1:0];
        OFF_DIR_B: gp_dir_b <= wr_val[B_W-1:0];
        OFF_OUT_A: gp_out_a <= wr_val[A_W-1:0];
        OFF_OUT_B: gp_out_b <= wr_val[B_W-1:0];
        default: ;
      endcase
    end
  end

  // card host holds an r pin unless it has released it
  assign card_own = {8{ctrl[C_CARD]}} & ~rel;

  // pin routing by fixed priority
  always_comb begin
    // unclaimed pins follow the gpio registers
    next_q_out = gp_out_a[7:0]; // RULE_19
    next_q_oe = gp_dir_a[7:0]; // RULE_19
    next_r_out = gp_out_a[15:8];
    next_r_oe = gp_dir_a[15:8];
    next_s_out = gp_out_b[7:0];
    next_s_oe = gp_dir_b[7:0];
    next_t_out = gp_out_b[11:8];
    next_t_oe = gp_dir_b[11:8];
    next_u_out = gp_out_b[17:12];
    next_u_oe = gp_dir_b[17:12];
    next_nand_din = 8'h00;
    next_tim_din = 8'h00;
    next_card_rcv = '0;
    next_disk_rcv = '0;
    next_serial_rx = 1'b1; // idle line when not routed
    // data port: nand host first, then alternate data
    if (ctrl[C_NAND]) begin
      next_q_out = nand_drv.dout; // RULE_01
      next_q_oe = nand_drv.oe; // RULE_01
      next_nand_din = q_in;
    end else if (ctrl[C_ALTQ] && ctrl[C_CARD]) begin
      next_q_out = card_drv.dout; // RULE_02
      next_q_oe = {8{card_drv.doe}};
      next_card_rcv.din = q_in;
    end else if (ctrl[C_ALTQ] && ctrl[C_DISK]) begin
      next_q_out = disk_drv.dout; // RULE_02
      next_q_oe = {8{disk_drv.doe}};
      next_disk_rcv.din = q_in;
    end
    // r1..r0 card address lines
    for (int i = 0; i < 2; i++) begin
      if (card_own[i]) begin
        next_r_out[i] = card_drv.addr[3+i]; // RULE_03
        next_r_oe[i] = 1'b1;
      end
    end
    // r2 card address or serial receive
    if (card_own[2]) begin
      next_r_out[2] = card_drv.addr[5]; // RULE_04
      next_r_oe[2] = 1'b1;
    end else if (ctrl[C_SER]) begin
      next_r_oe[2] = 1'b0; // RULE_04
      next_serial_rx = r_in[2];
    end
    // r3 card address or serial transmit
    if (card_own[3]) begin
      next_r_out[3] = card_drv.addr[6]; // RULE_05
      next_r_oe[3] = 1'b1;
    end else if (ctrl[C_SER]) begin
      next_r_out[3] = serial_tx; // RULE_05
      next_r_oe[3] = 1'b1;
    end
    // r7..r4 card address or timer channels 7..4
    for (int i = 4; i < 8; i++) begin
      if (card_own[i]) begin
        next_r_out[i] = card_drv.addr[i+3]; // RULE_06
        next_r_oe[i] = 1'b1;
      end else if (ctrl[C_TIM] && tsel[i]) begin
        next_r_out[i] = tim_drv.dout[i]; // RULE_06
        next_r_oe[i] = tim_drv.oe[i];
        next_tim_din[i] = r_in[i];
      end
    end
    // t3..t0 timer channels 3..0
    for (int i = 0; i < 4; i++) begin
      if (ctrl[C_TIM] && tsel[i]) begin
        next_t_out[i] = tim_drv.dout[i]; // RULE_13
        next_t_oe[i] = tim_drv.oe[i];
        next_tim_din[i] = t_in[i];
      end
    end
    // s and u ports: card host wins over disk host
    if (ctrl[C_CARD]) begin
      next_s_oe = 8'hFF;
      next_s_oe[7] = 1'b0; // RULE_07
      next_s_oe[2] = 1'b0; // RULE_11
      if (ctrl[C_IRQM]) begin
        next_card_rcv.irq = s_in[7]; // RULE_07
      end else begin
        next_card_rcv.ready = s_in[7]; // RULE_07
      end
      next_s_out[6] = card_drv.write_strobe; // RULE_08
      next_s_out[5] = card_drv.io_write; // RULE_09
      next_s_out[4] = card_drv.io_read; // RULE_09
      next_s_out[3] = card_drv.enable_hi; // RULE_10
      next_card_rcv.wide_io_select = s_in[2]; // RULE_11
      next_s_out[1] = card_drv.output_enable; // RULE_12
      next_s_out[0] = card_drv.enable_lo; // RULE_10
      next_u_out[5:3] = card_drv.addr[2:0]; // RULE_14
      next_u_out[2] = card_drv.register_select; // RULE_15
      next_u_oe = 6'h3C;
      next_card_rcv.input_ack = u_in[1]; // RULE_16
      next_card_rcv.wait_in = u_in[0]; // RULE_17
    end else if (ctrl[C_DISK]) begin
      next_s_oe[7] = 1'b0;
      next_disk_rcv.irq = s_in[7]; // RULE_07
      next_s_oe[6] = 1'b0;
      next_disk_rcv.dma_request = s_in[6]; // RULE_08
      next_s_out[5] = disk_drv.io_write; // RULE_09
      next_s_out[4] = disk_drv.io_read; // RULE_09
      next_s_out[3] = disk_drv.select_hi; // RULE_10
      next_s_out[0] = disk_drv.select_lo; // RULE_10
      next_s_oe[5:3] = 3'h7;
      next_s_oe[0] = 1'b1;
      next_u_out[5:3] = disk_drv.addr; // RULE_14
      next_u_oe[5:3] = 3'h7;
      next_u_out[1] = disk_drv.dma_ack; // RULE_16
      next_u_oe[1] = 1'b1;
      next_u_oe[0] = 1'b0;
      next_disk_rcv.io_ready = u_in[0]; // RULE_17
    end
  end

  // pad drive: every driver off during reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      q_oe <= 8'h00; // RULE_18
      r_oe <= 8'h00; // RULE_18
      s_oe <= 8'h00; // RULE_18
      t_oe <= 4'h0; // RULE_18
      u_oe <= 6'h00; // RULE_18
      q_out <= 8'h00;
      r_out <= 8'h00;
      s_out <= 8'h00;
      t_out <= 4'h0;
      u_out <= 6'h00;
    end else begin
      q_oe <= next_q_oe;
      r_oe <= next_r_oe;
      s_oe <= next_s_oe;
      t_oe <= next_t_oe;
      u_oe <= next_u_oe;
      q_out <= next_q_out;
      r_out <= next_r_out;
      s_out <= next_s_out;
      t_out <= next_t_out;
      u_out <= next_u_out;
    end
  end

  // pad inputs toward the peripherals and the status registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      nand_din <= 8'h00;
      tim_din <= 8'h00;
      card_rcv <= '0;
      disk_rcv <= '0;
      serial_rx <= 1'b1;
      pin_a <= GP_A_RESET;
      pin_b <= GP_B_RESET;
    end else begin
      nand_din <= next_nand_din;
      tim_din <= next_tim_din;
      card_rcv <= next_card_rcv;
      disk_rcv <= next_disk_rcv;
      serial_rx <= next_serial_rx;
      pin_a <= {r_in, q_in};
      pin_b <= {u_in, t_in, s_in};
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_nand_q;
    ctrl[C_NAND] |=> q_out == $past(nand_drv.dout) && q_oe == $past(nand_drv.oe);
  endproperty
  a_nand_q: assert property (p_nand_q) else $error("q not given to nand host"); // RULE_01

  property p_alt_q;
    !ctrl[C_NAND] && ctrl[C_ALTQ] && ctrl[C_CARD] |=> q_oe == {8{$past(card_drv.doe)}};
  endproperty
  a_alt_q: assert property (p_alt_q) else $error("q alternate data wrong"); // RULE_02

  property p_r0_addr;
    card_own[0] |=> r_oe[0] && r_out[0] == $past(card_drv.addr[3]);
  endproperty
  a_r0_addr: assert property (p_r0_addr) else $error("r0 not card address"); // RULE_03

  property p_r2_rx;
    !card_own[2] && ctrl[C_SER] |=> !r_oe[2] && serial_rx == $past(r_in[2]);
  endproperty
  a_r2_rx: assert property (p_r2_rx) else $error("r2 not serial receive"); // RULE_04

  property p_r3_tx;
    !card_own[3] && ctrl[C_SER] ##1 ctrl[C_SER] |-> r_oe[3] && r_out[3] == $past(serial_tx);
  endproperty
  a_r3_tx: assert property (p_r3_tx) else $error("r3 not serial transmit"); // RULE_05

  property p_s6_dma;
    ctrl[C_DISK] && !ctrl[C_CARD] |=> !s_oe[6] && disk_rcv.dma_request == $past(s_in[6]);
  endproperty
  a_s6_dma: assert property (p_s6_dma) else $error("s6 not disk dma request"); // RULE_08

  property p_s0_enable;
    ctrl[C_CARD] |=> s_oe[0] && s_out[0] == $past(card_drv.enable_lo);
  endproperty
  a_s0_enable: assert property (p_s0_enable) else $error("s0 not card enable"); // RULE_10

  property p_t0_timer;
    ctrl[C_TIM] && tsel[0] |=> t_out[0] == $past(tim_drv.dout[0]);
  endproperty
  a_t0_timer: assert property (p_t0_timer) else $error("t0 not timer channel"); // RULE_13

  property p_u1_ack;
    ctrl[C_DISK] && !ctrl[C_CARD] |=> u_oe[1] && u_out[1] == $past(disk_drv.dma_ack);
  endproperty
  a_u1_ack: assert property (p_u1_ack) else $error("u1 not disk dma ack"); // RULE_16

  property p_reset_hiz;
    $fell(rst) |-> q_oe == 8'h00 && r_oe == 8'h00 && s_oe == 8'h00 && u_oe == 6'h00;
  endproperty
  a_reset_hiz: assert property (p_reset_hiz) else $error("driver on after reset"); // RULE_18

  property p_gpio;
    ctrl == CTRL_RESET |=> q_oe == $past(gp_dir_a[7:0]) && s_out == $past(gp_out_b[7:0]);
  endproperty
  a_gpio: assert property (p_gpio) else $error("idle pin not gpio"); // RULE_19

endmodule

// *** testbench/ssp_media_model.sv ***
`timescale 1ns/1ns
// card and disk media on the shared pads, packed as {u,t,s,r,q}
module ssp_media_model (
  // device drive
  input wire logic [33:0] dev_out,
  input wire logic [33:0] dev_oe,
  // level the media puts on every pad the device leaves alone
  input wire logic [33:0] media,
  // resolved pad level back to the device
  output logic [33:0] pad_in
);
  // a driven pad shows the device value, a released pad shows the media level,
  // never a stale copy of the last driven value
  assign pad_in = (dev_out & dev_oe) | (media & ~dev_oe);
endmodule

// *** testbench/ssp_pin_mux_tb_top.sv ***
`timescale 1ns/1ns
`define CHK(nm, ex, gt) \
  begin \
    checked++; \
    if ((gt) !== (ex)) begin \
      n_mismatch++; \
      $display("CHECK FAILED %s exp %h got %h", nm, ex, gt); \
    end \
  end
// register-driven tests of the storage port selector
module ssp_pin_mux_tb_top
  import ssp_pkg::*;
();
  logic mclk, rst;
  // register bus
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  // pads
  logic [7:0] q_in, q_out, q_oe, r_in, r_out, r_oe, s_in, s_out, s_oe;
  logic [3:0] t_in, t_out, t_oe;
  logic [5:0] u_in, u_out, u_oe;
  logic [33:0] media, pad_in;
  // peripheral side
  ssp_bus8_type nand_drv, tim_drv;
  ssp_card_out_type card_drv;
  ssp_card_in_type card_rcv;
  ssp_disk_out_type disk_drv;
  ssp_disk_in_type disk_rcv;
  logic [7:0] nand_din, tim_din;
  logic serial_tx, serial_rx;
  logic [31:0] rdv;
  int n_mismatch = 0;
  int checked = 0;

  ssp_pin_mux ssp_pin_mux_i (.mclk(mclk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .q_in(q_in), .q_out(q_out), .q_oe(q_oe), .r_in(r_in),
    .r_out(r_out), .r_oe(r_oe), .s_in(s_in), .s_out(s_out), .s_oe(s_oe), .t_in(t_in),
    .t_out(t_out), .t_oe(t_oe), .u_in(u_in), .u_out(u_out), .u_oe(u_oe),
    .nand_drv(nand_drv), .nand_din(nand_din), .card_drv(card_drv), .card_rcv(card_rcv),
    .disk_drv(disk_drv), .disk_rcv(disk_rcv), .serial_tx(serial_tx), .serial_rx(serial_rx),
    .tim_drv(tim_drv), .tim_din(tim_din));

  ssp_media_model ssp_media_model_i (.dev_out({u_out, t_out, s_out, r_out, q_out}),
    .dev_oe({u_oe, t_oe, s_oe, r_oe, q_oe}), .media(media), .pad_in(pad_in));
  assign {u_in, t_in, s_in, r_in, q_in} = pad_in;

  // clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // one write: address and data offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      r = s_axi_bresp;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  // one read, data and response taken at the edge rvalid is seen
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      d = s_axi_rdata;
      r = s_axi_rresp;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask

  // write expecting an okay response
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axw(a, d, rsp);
    `CHK("bresp", RESP_OKAY, rsp)
  endtask

  // read expecting okay and a given word
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    axr(a, rdv, rsp);
    `CHK("rresp", RESP_OKAY, rsp)
    `CHK("rdata", e, rdv)
  endtask

  // let the pads follow the last change, then sample away from the edge
  task automatic settle();
    repeat (2) @(posedge mclk);
    #1;
  endtask

  // every drive enable off
  task automatic oe_off();
    `CHK("oe", 34'h0, {u_oe, t_oe, s_oe, r_oe, q_oe})
    `CHK("serial_rx", 1'b1, serial_rx)
  endtask

  task automatic close_out();
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // watchdog
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    close_out();
  end

  initial begin
    // inputs at time zero; peripherals try to drive during reset
    rst = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    media = {6'h02, 4'h5, 8'h84, 8'hF0, 8'h0F};
    nand_drv = {8'hFF, 8'hFF};
    tim_drv = {8'hFF, 8'hFF};
    card_drv = '1;
    disk_drv = '1;
    serial_tx = 1'b1;
    repeat (6) @(posedge mclk);
    // release on the edge; the design still sees reset at this edge
    rst <= 1'b0;
    #1;
    oe_off();
    @(posedge mclk);
    #1;
    oe_off();
    // unclaimed pins follow the general purpose registers
    wr(OFF_DIR_A, 32'hA55A);
    wr(OFF_OUT_A, 32'h3C96);
    wr(OFF_DIR_B, 32'h3FFFF);
    wr(OFF_OUT_B, 32'h2A5C3);
    settle();
    `CHK("a_oe", 16'hA55A, {r_oe, q_oe})
    `CHK("a_out", 16'h2412, {r_out, q_out} & 16'hA55A)
    `CHK("b_drv", {18'h3FFFF, 18'h2A5C3}, {u_oe, t_oe, s_oe, u_out, t_out, s_out})
    rd(OFF_PIN_A, 32'h7417);
    rd(OFF_PIN_B, 32'h2A5C3);
    wr(OFF_PIN_A, 32'h0);
    rd(OFF_PIN_A, 32'h7417);
    rd(OFF_CTRL, 32'h0);
    axr(8'h24, rdv, rsp);
    `CHK("rresp_unmapped", RESP_SLVERR, rsp)
    axw(8'h40, 32'hFF, rsp);
    `CHK("bresp_unmapped", RESP_SLVERR, rsp)
    // nand host owns the data port
    @(posedge mclk);
    nand_drv <= {8'hA5, 8'h3C};
    wr(OFF_CTRL, 32'h01);
    settle();
    `CHK("q_oe", 8'h3C, q_oe)
    `CHK("q_out", 8'h24, q_out & 8'h3C)
    `CHK("nand_din", 8'h27, nand_din)
    // card with alternate data, disk also on but lower priority
    @(posedge mclk);
    card_drv <= {11'h5A3, 7'b1011011, 8'hC6, 1'b1};
    disk_drv <= {3'h5, 5'b10101, 8'h3B, 1'b0};
    wr(OFF_CTRL, 32'h26);
    settle();
    `CHK("q_drv", 16'hFFC6, {q_oe, q_out})
    `CHK("nand_din", 8'h00, nand_din)
    `CHK("r_drv", 16'hFFB4, {r_oe, r_out})
    `CHK("s_oe", 8'h7B, s_oe)
    `CHK("s_out", 8'h5A, s_out & 8'h7B)
    `CHK("u_oe", 6'h3C, u_oe)
    `CHK("u_out", 6'h1C, u_out & 6'h3C)
    `CHK("card_rcv", 13'h16C6, card_rcv)
    `CHK("disk_rcv", 11'h000, disk_rcv)
    wr(OFF_CTRL, 32'h66);
    settle();
    `CHK("card_rcv_irq", 13'h0EC6, card_rcv)
    // card releases all r pins to serial port, timer and gpio
    @(posedge mclk);
    tim_drv <= {8'h9C, 8'h6A};
    wr(OFF_REL, 32'hFF);
    wr(OFF_TSEL, 32'hFF);
    wr(OFF_CTRL, 32'h1A);
    settle();
    `CHK("r_oe", 8'h69, r_oe)
    `CHK("r_out", 8'h08, r_out & 8'h69)
    `CHK("serial_rx", 1'b0, serial_rx)
    `CHK("t_drv", 8'hA8, {t_oe, t_out & 4'hA})
    `CHK("tim_din", 8'h9D, tim_din)
    // card takes back r1, r3, r4 and r6 only; the rest stay with gpio, serial and timer
    wr(OFF_REL, 32'hA5);
    settle();
    `CHK("r_drv_part", 16'h7B10, {r_oe, r_out & 8'h7B})
    // disk host alone, alternate data on the data port
    wr(OFF_CTRL, 32'h24);
    settle();
    `CHK("s_oe", 8'h3F, s_oe)
    `CHK("s_out", 8'h28, s_out & 8'h39)
    `CHK("u_oe", 6'h3E, u_oe)
    `CHK("u_out", 6'h2A, u_out & 6'h3A)
    `CHK("q_oe", 8'h00, q_oe)
    `CHK("disk_rcv", 11'h40F, disk_rcv)
    `CHK("card_rcv", 13'h0000, card_rcv)
    `CHK("r_t_oe", 12'hA5F, {r_oe, t_oe})
    // second reset in mid run drops every driver
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    oe_off();
    @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    oe_off();
    rd(OFF_CTRL, 32'h0);
    close_out();
  end
endmodule
